// ---- sssr_top.v ----
// Status summary and service request logic with standard event register
`timescale 1ns/1ps
`include "sssr_regs.vh"
module sssr_top (
    // Clock and reset
    input  wire        i_sys_clk,
    input  wire        i_rst_n,
    // Condition inputs
    input  wire [15:0] i_oper_cond,
    input  wire [15:0] i_ques_cond,
    input  wire [15:0] i_dev_cond,
    input  wire        i_sensor1_present,
    // Transition filters and enables of 16-bit groups
    input  wire [15:0] i_oper_ptr,
    input  wire [15:0] i_oper_ntr,
    input  wire [15:0] i_oper_enab,
    input  wire [15:0] i_ques_ptr,
    input  wire [15:0] i_ques_ntr,
    input  wire [15:0] i_ques_enab,
    input  wire [15:0] i_dev_ptr,
    input  wire [15:0] i_dev_ntr,
    input  wire [15:0] i_dev_enab,
    // Group event queries, one-cycle strobes
    input  wire        i_oper_evt_rd,
    input  wire        i_ques_evt_rd,
    input  wire        i_dev_evt_rd,
    // Queue states
    input  wire        i_out_queue_busy,
    input  wire        i_err_queue_busy,
    // Standard event sources, one-cycle strobes
    input  wire [7:0]  i_std_evt,
    // Common commands, one-cycle strobes
    input  wire        i_cls,
    input  wire        i_sre_wr,
    input  wire [7:0]  i_sre_data,
    input  wire        i_ese_wr,
    input  wire [7:0]  i_ese_data,
    input  wire        i_esr_rd,
    input  wire        i_stb_rd,
    input  wire        i_spoll,
    // Answers
    output reg  [7:0]  o_esr_data,
    output reg         o_esr_valid,
    output reg  [7:0]  o_stb_data,
    output reg         o_stb_valid,
    output reg  [7:0]  o_spoll_data,
    output reg         o_spoll_valid,
    output reg  [7:0]  o_sre,
    output reg  [7:0]  o_ese,
    output reg  [15:0] o_oper_event,
    output reg  [15:0] o_ques_event,
    output reg  [15:0] o_dev_event,
    output reg  [7:0]  o_status_byte,
    output reg         o_srq
);
    // ==========================================
    // Status groups
    wire [15:0] oper_event;
    wire [15:0] ques_event;
    wire [15:0] dev_event;
    wire        oper_sum;
    wire        ques_sum;
    wire        dev_sum;
    wire [15:0] dev_cond_full;

    // Sensor one presence drives device-status bit 1
    assign dev_cond_full = (i_dev_cond & ~(16'h0001 << `SSSR_DEV_SENSOR1))
                         | ({15'h0000, i_sensor1_present} << `SSSR_DEV_SENSOR1);

    sssr_group #(.W(`SSSR_GRP_W)) u_oper (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_cond    (i_oper_cond),
        .i_ptr     (i_oper_ptr),
        .i_ntr     (i_oper_ntr),
        .i_enab    (i_oper_enab),
        .i_clear   (i_oper_evt_rd | i_cls),
        .o_event   (oper_event),
        .o_summary (oper_sum)
    );

    sssr_group #(.W(`SSSR_GRP_W)) u_ques (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_cond    (i_ques_cond),
        .i_ptr     (i_ques_ptr),
        .i_ntr     (i_ques_ntr),
        .i_enab    (i_ques_enab),
        .i_clear   (i_ques_evt_rd | i_cls),
        .o_event   (ques_event),
        .o_summary (ques_sum)
    );

    sssr_group #(.W(`SSSR_GRP_W)) u_dev (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_cond    (dev_cond_full),
        .i_ptr     (i_dev_ptr),
        .i_ntr     (i_dev_ntr),
        .i_enab    (i_dev_enab),
        .i_clear   (i_dev_evt_rd | i_cls),
        .o_event   (dev_event),
        .o_summary (dev_sum)
    );

    // ==========================================
    // Standard event register and masks
    reg  [7:0] sel_reg;
    reg  [7:0] sel_next;
    reg  [7:0] ese_next;
    reg  [7:0] sre_next;
    wire [7:0] std_in = i_std_evt & `SSSR_SE_MASK;

    always @*
    begin
        if (i_cls || i_esr_rd)
            sel_next = std_in;
        else
            sel_next = sel_reg | std_in;
        ese_next = o_ese;
        if (i_ese_wr)
            ese_next = i_ese_data;
        sre_next = o_sre;
        if (i_sre_wr)
            sre_next = i_sre_data & ~(8'h01 << `SSSR_SB_RQS);
    end

    // ==========================================
    // Summary byte
    reg  [7:0] sum_next;
    wire       esb = |(sel_reg & o_ese);
    wire       rqs = |(sum_next & o_sre);

    always @*
    begin
        sum_next = 8'h00;
        sum_next[`SSSR_SB_DEV]  = dev_sum;
        sum_next[`SSSR_SB_ERRQ] = i_err_queue_busy;
        sum_next[`SSSR_SB_QUES] = ques_sum;
        sum_next[`SSSR_SB_MAV]  = i_out_queue_busy;
        sum_next[`SSSR_SB_ESB]  = esb;
        sum_next[`SSSR_SB_OPER] = oper_sum;
    end

    // ==========================================
    // Request and service request latch
    reg  rqs_reg;
    reg  rqs_prev_reg;
    wire rqs_rise = rqs && !rqs_prev_reg;

    // ==========================================
    // Standard event latch, power-on bit set by reset
    always @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            sel_reg <= `SSSR_SEL_RST;
        end
        else
        begin
            sel_reg <= sel_next;
        end
    end

    // ==========================================
    // Standard event enable mask
    always @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            o_ese <= `SSSR_ESE_RST;
        end
        else
        begin
            o_ese <= ese_next;
        end
    end

    // ==========================================
    // Service request enable mask
    always @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            o_sre <= `SSSR_SRE_RST;
        end
        else
        begin
            o_sre <= sre_next;
        end
    end

    // ==========================================
    // Request edge detector, idle low like the summary after reset
    always @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            rqs_prev_reg <= 1'b0;
        end
        else
        begin
            rqs_prev_reg <= rqs;
        end
    end

    // ==========================================
    // Request latch: set by a new rising summary, cleared by a poll or a falling summary
    always @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            rqs_reg <= 1'b0;
        end
        else if (rqs_rise)
        begin
            rqs_reg <= 1'b1;
        end
        else if (i_spoll || !rqs)
        begin
            rqs_reg <= 1'b0;
        end
    end

    // ==========================================
    // Registered outputs
    // Places a request bit into a summary byte
    function [7:0] sssr_put_rqs;
        input [7:0] base;
        input       req;
        begin
            sssr_put_rqs = base | ({7'h00, req} << `SSSR_SB_RQS);
        end
    endfunction

    wire [7:0] live_byte = sssr_put_rqs(sum_next, rqs);
    wire [7:0] poll_byte = sssr_put_rqs(sum_next, rqs_reg);

    // ==========================================
    // Standard event query answer, data is the register before its clear
    always @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            o_esr_data  <= 8'h00;
            o_esr_valid <= 1'b0;
        end
        else
        begin
            o_esr_valid <= i_esr_rd;
            o_esr_data  <= i_esr_rd ? sel_reg : 8'h00;
        end
    end

    // ==========================================
    // Summary query answer, request bit left untouched
    always @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            o_stb_data  <= 8'h00;
            o_stb_valid <= 1'b0;
        end
        else
        begin
            o_stb_valid <= i_stb_rd;
            o_stb_data  <= i_stb_rd ? live_byte : 8'h00;
        end
    end

    // ==========================================
    // Serial poll answer, request bit from the latch
    always @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            o_spoll_data  <= 8'h00;
            o_spoll_valid <= 1'b0;
        end
        else
        begin
            o_spoll_valid <= i_spoll;
            o_spoll_data  <= i_spoll ? poll_byte : 8'h00;
        end
    end

    // ==========================================
    // Group event mirrors
    always @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            o_oper_event <= `SSSR_GRP_RST;
            o_ques_event <= `SSSR_GRP_RST;
            o_dev_event  <= `SSSR_GRP_RST;
        end
        else
        begin
            o_oper_event <= oper_event & `SSSR_GRP_MASK;
            o_ques_event <= ques_event & `SSSR_GRP_MASK;
            o_dev_event  <= dev_event & `SSSR_GRP_MASK;
        end
    end

    // ==========================================
    // Live summary byte
    always @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            o_status_byte <= 8'h00;
        end
        else
        begin
            o_status_byte <= live_byte;
        end
    end

    // ==========================================
    // Service request line, dropped at the clock edge that ends the poll cycle
    always @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            o_srq <= 1'b0;
        end
        else
        begin
            o_srq <= rqs_reg && !i_spoll;
        end
    end
endmodule

// ---- sssr_regs.vh ----
// Field positions, reset values, masks and widths of the status summary block
`ifndef SSSR_REGS_VH
`define SSSR_REGS_VH

// Summary byte field positions
`define SSSR_SB_UNUSED      0
`define SSSR_SB_DEV         1
`define SSSR_SB_ERRQ        2
`define SSSR_SB_QUES        3
`define SSSR_SB_MAV         4
`define SSSR_SB_ESB         5
`define SSSR_SB_RQS         6
`define SSSR_SB_OPER        7

// Standard event field positions
`define SSSR_SE_OPC         0
`define SSSR_SE_UNUSED      1
`define SSSR_SE_QYE         2
`define SSSR_SE_DDE         3
`define SSSR_SE_EXE         4
`define SSSR_SE_CME         5
`define SSSR_SE_URQ         6
`define SSSR_SE_PON         7

// Device-status sensor presence bit, operation upper limit fail bit
`define SSSR_DEV_SENSOR1    1
`define SSSR_OPER_ULF       12

// Widths
`define SSSR_GRP_W          16
`define SSSR_BYTE_W         8

// Reset values and masks
`define SSSR_SRE_RST        8'h00
`define SSSR_ESE_RST        8'h00
`define SSSR_SEL_RST        8'h80
`define SSSR_GRP_RST        16'h0000
`define SSSR_GRP_MASK       16'h7fff
`define SSSR_SE_MASK        8'hfd

`endif

// ---- sssr_group.v ----
// One 16-bit condition, transition filter, event and enable status group
`timescale 1ns/1ps
module sssr_group #(
    parameter W = 16
) (
    // Clock and reset
    input  wire         i_sys_clk,
    input  wire         i_rst_n,
    // Group control
    input  wire [W-1:0] i_cond,
    input  wire [W-1:0] i_ptr,
    input  wire [W-1:0] i_ntr,
    input  wire [W-1:0] i_enab,
    input  wire         i_clear,
    // Group state
    output reg  [W-1:0] o_event,
    output wire         o_summary
);
    reg  [W-1:0] cond_reg;
    wire [W-1:0] mask = {1'b0, {(W-1){1'b1}}};
    wire [W-1:0] trans = ((i_cond & ~cond_reg & i_ptr) | (~i_cond & cond_reg & i_ntr)) & mask;

    // ==========================================
    // Event latch
    always @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            cond_reg <= {W{1'b0}};
            o_event  <= {W{1'b0}};
        end
        else
        begin
            cond_reg <= i_cond & mask;
            if (i_clear)
                o_event <= trans;
            else
                o_event <= (o_event | trans) & mask;
        end
    end

    assign o_summary = |(o_event & i_enab);
endmodule

// ---- sssr_top_chk.sv ----
// Port checker for the status summary and service request block
`timescale 1ns/1ps
module sssr_top_chk (
    // Clock, reset and strobes
    input wire        i_sys_clk, i_rst_n, i_oper_evt_rd, i_cls, i_spoll, i_esr_rd, i_stb_rd,
    input wire        i_out_queue_busy, i_err_queue_busy, i_sre_wr, i_ese_wr,
    // Answers and request line
    input wire        o_esr_valid, o_stb_valid, o_spoll_valid, o_srq,
    input wire [7:0]  i_sre_data, i_ese_data, o_sre, o_ese, o_status_byte,
    input wire [15:0] i_oper_cond, i_oper_ptr, i_oper_enab,
    input wire [15:0] o_oper_event, o_ques_event, o_dev_event
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // ==========
    // Upper limit path to the request line
    sequence s_ulf_in;
        $rose(i_oper_cond[12]) && i_oper_ptr[12] && i_oper_enab[12] && o_sre[7]
            && !o_status_byte[7] && !i_cls && !i_oper_evt_rd;
    endsequence
    sequence s_ulf_out;
        o_oper_event[12] ##1 o_srq;
    endsequence
    // ==========
    // Properties
    a_unused_zero: assert property (!o_status_byte[0])
        else $error("summary bit 0 set");
    a_top_bit_zero: assert property (!(o_oper_event[15] | o_ques_event[15] | o_dev_event[15]))
        else $error("group top bit set");
    a_queue_bits: assert property (o_status_byte[4] == $past(i_out_queue_busy)
        && o_status_byte[2] == $past(i_err_queue_busy)) else $error("queue bits wrong");
    a_answer_valid: assert property ({o_esr_valid, o_stb_valid, o_spoll_valid}
        == $past({i_esr_rd, i_stb_rd, i_spoll})) else $error("answer timing wrong");
    a_poll_drops: assert property (i_spoll |=> !o_srq)
        else $error("request kept after poll");
    a_sre_track: assert property (o_sre == ($past(i_sre_wr) ?
        $past(i_sre_data) & 8'hbf : $past(o_sre))) else $error("request mask wrong");
    a_ese_track: assert property (o_ese == ($past(i_ese_wr) ?
        $past(i_ese_data) : $past(o_ese))) else $error("event mask wrong");
    a_ulf_srq: assert property (s_ulf_in |-> ##2 s_ulf_out)
        else $error("limit fail request missing");
    a_event_hold: assert property (($past(o_oper_event) & ~o_oper_event) != 16'h0000
        |-> $past(i_oper_evt_rd | i_cls) || $past(i_oper_evt_rd | i_cls, 2))
        else $error("event bit dropped");
endmodule

bind sssr_top sssr_top_chk sssr_top_chk_i (.*);

// ---- sssr_host.sv ----
// Bus controller model that answers service requests with serial polls
`timescale 1ns/1ps
module sssr_host (
    // Clock and reset
    input  wire       i_sys_clk,
    input  wire       i_rst_n,
    // Request line and poll control
    input  wire       i_srq,
    input  wire       i_auto,
    input  wire [3:0] i_wait,
    // Poll strobe
    output reg        o_spoll
);
    reg [3:0] wait_reg;
    // ==========
    // Poll once the request line has stood for the set delay
    always @(posedge i_sys_clk)
    begin
        if (!i_rst_n || !i_auto || !i_srq || o_spoll)
        begin
            wait_reg <= 4'h0;
            o_spoll  <= 1'b0;
        end
        else if (wait_reg == i_wait)
            o_spoll <= 1'b1;
        else
            wait_reg <= wait_reg + 4'h1;
    end
endmodule

// ---- tb_sssr_top.sv ----
// Testbench for the status summary and service request block
`timescale 1ns/1ps
module tb_sssr_top;
    logic        i_sys_clk, i_rst_n, i_sensor1_present, i_out_queue_busy, i_err_queue_busy;
    logic        auto;
    logic [3:0]  wt;
    logic [15:0] i_oper_cond, i_ques_cond, i_oper_ptr, i_oper_enab, i_ques_ptr, i_ques_enab;
    logic [15:0] i_dev_ptr, i_dev_ntr, i_dev_enab;
    logic [5:0]  st;
    logic [1:0]  grd;
    logic [7:0]  i_std_evt, dat, spd;
    wire         i_cls, i_sre_wr, i_ese_wr, i_esr_rd, i_stb_rd, i_oper_evt_rd, i_spoll;
    wire  [7:0]  i_sre_data, i_ese_data, o_esr_data, o_stb_data, o_spoll_data, o_sre, o_ese;
    wire  [7:0]  o_status_byte;
    wire  [15:0] o_oper_event, o_ques_event, o_dev_event;
    wire         o_esr_valid, o_stb_valid, o_spoll_valid, o_srq;
    int          error_cnt, cmp_count;
    assign {i_oper_evt_rd, i_stb_rd, i_esr_rd, i_ese_wr, i_sre_wr, i_cls} = st;
    assign i_sre_data = dat;
    assign i_ese_data = dat;
    sssr_top sssr_top_i (.i_dev_cond(16'h0000), .i_oper_ntr(16'h0000), .i_ques_ntr(16'h0000),
        .i_ques_evt_rd(grd[0]), .i_dev_evt_rd(grd[1]), .*);
    sssr_host sssr_host_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_srq(o_srq),
        .i_auto(auto), .i_wait(wt), .o_spoll(i_spoll));
    // ==========
    // Clock, poll capture and watchdog
    initial
    begin
        i_sys_clk = 1'b0;
        forever #25 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk)
        if (o_spoll_valid === 1'b1)
            spd <= o_spoll_data;
    initial
    begin
        #100000;
        error_cnt++;
        end_of_test();
    end
    // ==========
    // Tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic cmd(input logic [5:0] s, input logic [7:0] d);
        @(posedge i_sys_clk);
        st  <= s;
        dat <= d;
        @(posedge i_sys_clk);
        st <= 6'h00;
        #1;
    endtask
    task automatic evt(input logic [7:0] e);
        @(posedge i_sys_clk) i_std_evt <= e;
        @(posedge i_sys_clk) i_std_evt <= 8'h00;
        cyc(3);
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ==========
    // Tests
    initial
    begin
        {i_rst_n, i_sensor1_present, i_out_queue_busy, i_err_queue_busy, auto, wt, i_oper_cond,
            i_ques_cond, i_oper_ptr, i_oper_enab, i_ques_ptr, i_ques_enab, i_dev_ptr,
            i_dev_ntr, i_dev_enab, st, grd, i_std_evt, dat, spd} = '0;
        error_cnt = 0;
        cmp_count = 0;
        cyc(1);
        @(posedge i_sys_clk) i_rst_n <= 1'b1;
        cyc(1);
        chk("sre", 16'h0000, o_sre);
        cmd(6'h08, 8'h00);
        chk("esr pon", 16'h0080, o_esr_data);
        cmd(6'h08, 8'h00);
        chk("esr read", 16'h0000, o_esr_data);
        $display("test reset done");
        cmd(6'h04, 8'hff);
        evt(8'hff);
        chk("sb esb", 16'h0020, o_status_byte);
        cmd(6'h08, 8'h00);
        chk("esr map", 16'h00fd, o_esr_data);
        cyc(2);
        chk("sb esb read", 16'h0000, o_status_byte);
        cmd(6'h04, 8'h04);
        evt(8'h08);
        chk("sb masked", 16'h0000, o_status_byte);
        cmd(6'h01, 8'h00);
        cmd(6'h08, 8'h00);
        chk("esr cls", 16'h0000, o_esr_data);
        cmd(6'h04, 8'h00);
        chk("ese zero", 16'h0000, o_ese);
        $display("test standard events done");
        @(posedge i_sys_clk) {i_out_queue_busy, i_err_queue_busy} <= 2'b11;
        cyc(2);
        chk("sb queues", 16'h0014, o_status_byte);
        @(posedge i_sys_clk) i_out_queue_busy <= 1'b0;
        cyc(2);
        chk("sb mav clr", 16'h0004, o_status_byte);
        @(posedge i_sys_clk) i_err_queue_busy <= 1'b0;
        cyc(2);
        chk("sb errq clr", 16'h0000, o_status_byte);
        $display("test queues done");
        @(posedge i_sys_clk) {i_oper_ptr, i_oper_enab} <= {2{16'h1000}};
        cmd(6'h02, 8'hff);
        chk("sre bits", 16'h00bf, o_sre);
        @(posedge i_sys_clk) i_oper_cond <= 16'h9000;
        cyc(5);
        chk("oper evt", 16'h1000, o_oper_event);
        chk("srq", 16'h0001, o_srq);
        cmd(6'h10, 8'h00);
        chk("stb", 16'h00c0, o_stb_data);
        chk("srq kept", 16'h0001, o_srq);
        @(posedge i_sys_clk) {auto, wt, i_oper_cond} <= {1'b1, 4'h3, 16'h0000};
        cyc(10);
        chk("poll", 16'h00c0, spd);
        chk("srq poll", 16'h0000, o_srq);
        chk("oper hold", 16'h1000, o_oper_event);
        cmd(6'h20, 8'h00);
        cyc(2);
        chk("sb oper read", 16'h0000, o_status_byte);
        $display("test limit request done");
        @(posedge i_sys_clk) {wt, i_dev_ptr, i_dev_ntr, i_dev_enab} <= {4'h0, {3{16'h0002}}};
        @(posedge i_sys_clk) i_sensor1_present <= 1'b1;
        cyc(10);
        chk("dev on", 16'h0002, o_dev_event);
        chk("poll dev", 16'h0042, spd);
        cmd(6'h01, 8'h00);
        cyc(2);
        chk("dev cls", 16'h0000, o_dev_event);
        @(posedge i_sys_clk) i_sensor1_present <= 1'b0;
        cyc(10);
        chk("dev off", 16'h0002, o_dev_event);
        chk("srq dev", 16'h0000, o_srq);
        cmd(6'h01, 8'h00);
        @(posedge i_sys_clk) {i_ques_ptr, i_ques_enab, i_ques_cond} <= {3{16'h0008}};
        cyc(10);
        chk("ques evt", 16'h0008, o_ques_event);
        chk("sb ques", 16'h0048, o_status_byte);
        chk("poll ques", 16'h0048, spd);
        @(posedge i_sys_clk) grd <= 2'b11;
        @(posedge i_sys_clk) grd <= 2'b00;
        cyc(2);
        chk("ques read", 16'h0000, o_ques_event);
        chk("sb ques read", 16'h0000, o_status_byte);
        $display("test sensor and quality done");
        end_of_test();
    end
endmodule
